//--- logic/led_sink_pkg.sv
// Shared constants and types for the latched serial LED sink driver
package led_sink_pkg;
    // Default channel count, either 8 or 16
    localparam int CHANNELS_DEF = 16;
    // Number of clock steps in each mode-change sequence
    localparam int SEQ_STEPS = 5;
    // Step index width for the mode-change sequencer
    localparam int STEP_W = 3;
    // Expected blank level per entry step, bit i is step i
    localparam logic [4:0] ENTRY_BLANK_LVL = 5'h1d;
    // Expected latch_load level per entry step
    localparam logic [4:0] ENTRY_LOAD_LVL = 5'h08;
    // Expected blank level per exit step
    localparam logic [4:0] EXIT_BLANK_LVL = 5'h15;
    // Expected latch_load level per exit step
    localparam logic [4:0] EXIT_LOAD_LVL = 5'h00;
    // Least clock pulses during one detection period
    localparam logic [1:0] MIN_DETECT_PULSES = 2'h3;
    // Reset value of every shift stage and latch
    localparam logic SHIFT_RESET = 1'b0;
    // Error bit value for a disabled or failing channel
    localparam logic ERR_BIT_FAIL = 1'b0;
    // Operating modes
    typedef enum logic {MODE_NORMAL, MODE_TEST} mode_t;
endpackage

//--- logic/led_mode_sequencer.sv
// Mode-change sequencer between normal and open_lamp_test modes
`timescale 1ns/1ns
module led_mode_sequencer #(
    parameter logic [4:0] ENTRY_BLANK = led_sink_pkg::ENTRY_BLANK_LVL,
    parameter logic [4:0] ENTRY_LOAD = led_sink_pkg::ENTRY_LOAD_LVL,
    parameter logic [4:0] EXIT_BLANK = led_sink_pkg::EXIT_BLANK_LVL,
    parameter logic [4:0] EXIT_LOAD = led_sink_pkg::EXIT_LOAD_LVL
) (
    input wire logic i_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_clear, // Lockout clear, back to normal
    input wire logic i_step, // Serial clock rising edge
    input wire logic i_blank, // Output blank pin level
    input wire logic i_load, // Latch load pin level
    output logic o_test_mode, // High in open_lamp_test mode
    output logic o_busy, // Sequence in progress or step taken
    output logic o_mode_flip // Pulse when the mode toggles
);
    // Current mode and step index
    led_sink_pkg::mode_t mode_q;
    logic [led_sink_pkg::STEP_W-1:0] step_q;
    // Table for the mode we would leave
    logic [4:0] tbl_blank;
    logic [4:0] tbl_load;
    logic hit_now; // Pins match current step
    logic hit_first; // Pins match step zero

    // Select the table that leads out of the present mode
    always_comb begin
        case (mode_q)
            led_sink_pkg::MODE_NORMAL: begin
                tbl_blank = ENTRY_BLANK;
                tbl_load = ENTRY_LOAD;
            end
            default: begin
                tbl_blank = EXIT_BLANK;
                tbl_load = EXIT_LOAD;
            end
        endcase
    end

    // Compare sampled pins with the expected step levels
    assign hit_now = (i_blank == tbl_blank[step_q])
        && (i_load == tbl_load[step_q]);
    assign hit_first = (i_blank == tbl_blank[0]) && (i_load == tbl_load[0]);
    assign o_busy = (step_q != '0) || (i_step && hit_now);
    assign o_mode_flip = i_ce && !i_clear && i_step && hit_now
        && (step_q == led_sink_pkg::STEP_W'(led_sink_pkg::SEQ_STEPS - 1));
    assign o_test_mode = (mode_q == led_sink_pkg::MODE_TEST);

    // Step counter advances on each matching serial clock edge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            step_q <= '0;
        end else if (i_ce) begin
            if (i_clear) begin
                step_q <= '0;
            end else if (i_step) begin
                if (o_mode_flip) begin
                    step_q <= '0;
                end else if (hit_now) begin
                    step_q <= step_q + 1'b1;
                end else if (hit_first) begin
                    step_q <= led_sink_pkg::STEP_W'(1);
                end else begin
                    step_q <= '0;
                end
            end
        end
    end

    // Mode flips after the fifth matching step
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= led_sink_pkg::MODE_NORMAL;
        end else if (i_ce) begin
            if (i_clear) begin
                mode_q <= led_sink_pkg::MODE_NORMAL;
            end else if (o_mode_flip) begin
                mode_q <= (mode_q == led_sink_pkg::MODE_NORMAL)
                    ? led_sink_pkg::MODE_TEST : led_sink_pkg::MODE_NORMAL;
            end
        end
    end
endmodule

//--- logic/led_open_capture.sv
// Open-lamp detection capture of per-channel error bits
`timescale 1ns/1ns
module led_open_capture #(
    parameter int CHANNELS = led_sink_pkg::CHANNELS_DEF
) (
    input wire logic i_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_clear, // Lockout clear
    input wire logic i_test_mode, // Open_lamp_test mode active
    input wire logic i_step, // Serial clock rising edge
    input wire logic i_blank, // Output blank pin level
    input wire logic [CHANNELS-1:0] i_enabled, // Latched channel enables
    input wire logic [CHANNELS-1:0] i_drop_ok, // Drop meets threshold
    output logic o_load, // Pulse: load error bits into shift
    output logic [CHANNELS-1:0] o_err // Captured error bits
);
    logic [1:0] pulses_q; // Saturating pulse count while low
    logic blank_q; // Blank level one cycle ago

    // Load on blank rising after a long enough detection period
    assign o_load = i_ce && !i_clear && i_test_mode && i_blank && !blank_q
        && (pulses_q >= led_sink_pkg::MIN_DETECT_PULSES);

    // Track blank and count clock pulses while it is low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blank_q <= 1'b1;
            pulses_q <= '0;
        end else if (i_ce) begin
            blank_q <= i_blank;
            if (i_blank || i_clear || !i_test_mode) begin
                pulses_q <= '0; // Period ends, start over
            end else if (i_step && pulses_q != 2'h3) begin
                pulses_q <= pulses_q + 1'b1;
            end
        end
    end

    // Sample comparators on each serial clock edge in test mode while blank is low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_err <= {CHANNELS{led_sink_pkg::ERR_BIT_FAIL}};
        end else if (i_ce && i_test_mode && !i_blank && i_step) begin
            o_err <= i_enabled & i_drop_ok;
        end
    end
endmodule

//--- logic/led_sink_driver.sv
// Top of the serial latched LED sink driver with open-lamp test
`timescale 1ns/1ns

// Operation
// - Rising serial clock shifts input toward output
// - Latch load high makes latches follow shift
// - Output blank high turns every sink off
// - Blank never alters latches; latches drive sinks
// - Five pulse sequences enter and leave test
// - Sequence steps sampled on serial clock edge
// - Entry sequence shifts but does not latch
// - Test mode compares drops while blank low
// - Error bit one only when enabled and good
// - Blank rising loads error bits into shift
// - Detection sequence may repeat any number times
// - Test mode still accepts shifted latched data
// - Eight or sixteen channels, last stage cascades
// - Lockout recovery clears stages, normal mode
// - Supply low lockout forces all sinks off
// - Overheat forces off; test mode clears shift
module led_sink_driver #(
    parameter int CHANNELS = led_sink_pkg::CHANNELS_DEF,
    parameter logic [4:0] ENTRY_BLANK = led_sink_pkg::ENTRY_BLANK_LVL,
    parameter logic [4:0] ENTRY_LOAD = led_sink_pkg::ENTRY_LOAD_LVL,
    parameter logic [4:0] EXIT_BLANK = led_sink_pkg::EXIT_BLANK_LVL,
    parameter logic [4:0] EXIT_LOAD = led_sink_pkg::EXIT_LOAD_LVL
) (
    input wire logic I_CORE_CLK, // Core clock, 100 MHz
    input wire logic I_NRST, // Async reset, active low
    input wire logic I_CE, // Clock enable, freezes state when low
    input wire logic I_SCLK, // Serial clock pin level
    input wire logic I_SDI, // Serial data in
    input wire logic I_LATCH_LOAD, // Latch load, latches follow if high
    input wire logic I_OUTPUT_BLANK, // Output blank, sinks off if high
    input wire logic I_SUPPLY_LOW_LOCKOUT, // Supply low indication
    input wire logic I_OVERHEAT_SHUTOFF, // Overheat indication
    input wire logic [CHANNELS-1:0] I_DROP_OK, // Per channel drop >= thr
    output logic O_SDO, // Serial data out, cascade
    output logic [CHANNELS-1:0] O_SINK_ON, // Sink output on
    output logic O_TEST_MODE // High in open_lamp_test mode
);
    // Refuse channel counts the part does not offer
    generate
        if (CHANNELS != 8 && CHANNELS != 16) begin : g_bad_channels
            $error("CHANNELS must be 8 or 16");
        end
    endgenerate

    // Serial clock level one cycle ago
    logic sclk_q;
    // One cycle pulse on serial clock rising edge
    logic sclk_rise;
    // Shift register stages, bit 0 is first stage
    logic [CHANNELS-1:0] shift_q;
    // Next value of the shift register
    logic [CHANNELS-1:0] shift_d;
    // Output latches
    logic [CHANNELS-1:0] latch_q;
    // Test mode flag from the sequencer
    logic test_mode;
    // Sequence in progress, blocks latch loading
    logic seq_busy;
    // Mode toggles this cycle
    logic mode_flip;
    // Error bits ready to load
    logic err_load;
    // Captured error bits
    logic [CHANNELS-1:0] err_bits;
    // Latches may copy the shift stages
    logic latch_open;
    // Common force-off term
    logic force_off;
    // Sink enable before the output flops
    logic [CHANNELS-1:0] sink_d;

    // Serial clock edge detection, inputs are synchronous
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sclk_q <= 1'b0;
        end else if (I_CE) begin
            sclk_q <= I_SCLK;
        end
    end

    // Rising edge of the serial clock
    assign sclk_rise = I_SCLK && !sclk_q;

    // Mode-change sequencer
    led_mode_sequencer #(
        .ENTRY_BLANK(ENTRY_BLANK),
        .ENTRY_LOAD(ENTRY_LOAD),
        .EXIT_BLANK(EXIT_BLANK),
        .EXIT_LOAD(EXIT_LOAD)
    ) u_seq (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_ce(I_CE),
        .i_clear(I_SUPPLY_LOW_LOCKOUT),
        .i_step(sclk_rise),
        .i_blank(I_OUTPUT_BLANK),
        .i_load(I_LATCH_LOAD),
        .o_test_mode(test_mode),
        .o_busy(seq_busy),
        .o_mode_flip(mode_flip)
    );

    // Open-lamp detection capture
    led_open_capture #(
        .CHANNELS(CHANNELS)
    ) u_cap (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_ce(I_CE),
        .i_clear(I_SUPPLY_LOW_LOCKOUT),
        .i_test_mode(test_mode),
        .i_step(sclk_rise),
        .i_blank(I_OUTPUT_BLANK),
        .i_enabled(latch_q),
        .i_drop_ok(I_DROP_OK),
        .o_load(err_load),
        .o_err(err_bits)
    );

    // Shift register next value, in priority order
    always_comb begin
        shift_d = shift_q;
        if (I_SUPPLY_LOW_LOCKOUT) begin
            // Lockout holds every stage clear until recovery
            shift_d = {CHANNELS{led_sink_pkg::SHIFT_RESET}};
        end else if (test_mode && I_OVERHEAT_SHUTOFF) begin
            // Overheat in test mode reports failure everywhere
            shift_d = {CHANNELS{led_sink_pkg::ERR_BIT_FAIL}};
        end else if (err_load) begin
            // Detection result replaces the shift contents
            shift_d = err_bits;
        end else if (sclk_rise) begin
            // Shift keeps running even during sequences
            shift_d = {shift_q[CHANNELS-2:0], I_SDI};
        end
    end

    // Shift register state
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            shift_q <= {CHANNELS{led_sink_pkg::SHIFT_RESET}};
        end else if (I_CE) begin
            shift_q <= shift_d;
        end
    end

    // Last stage drives the cascade output
    assign O_SDO = shift_q[CHANNELS-1];

    // Latches open while latch_load high and no sequence running
    assign latch_open = I_LATCH_LOAD && !seq_busy && !mode_flip;

    // Force every sink off on lockout or overheat
    assign force_off = I_SUPPLY_LOW_LOCKOUT || I_OVERHEAT_SHUTOFF;

    // Per channel latch and sink gating
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            // Transparent latch, modelled as a follower flop
            always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
                if (!I_NRST) begin
                    latch_q[ch] <= led_sink_pkg::SHIFT_RESET;
                end else if (I_CE) begin
                    if (I_SUPPLY_LOW_LOCKOUT) begin
                        latch_q[ch] <= led_sink_pkg::SHIFT_RESET;
                    end else if (latch_open) begin
                        // Follows shifted data, also in test mode
                        latch_q[ch] <= shift_d[ch];
                    end
                end
            end

            // Blank and overheat gating never touch the latch; lockout clears it
            assign sink_d[ch] = latch_q[ch] && !I_OUTPUT_BLANK
                && !force_off;

            // Registered sink drive
            always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
                if (!I_NRST) begin
                    O_SINK_ON[ch] <= 1'b0;
                end else if (I_CE) begin
                    O_SINK_ON[ch] <= sink_d[ch];
                end
            end
        end
    endgenerate

    // Registered copy of the mode flag
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_TEST_MODE <= 1'b0;
        end else if (I_CE) begin
            O_TEST_MODE <= test_mode;
        end
    end
endmodule

//--- testbench/led_sink_driver_sva.sv
// Port-level checks for the LED sink driver
`timescale 1ns/1ns
module led_sink_driver_sva #(
    parameter int CHANNELS = 16
) (
    input wire logic I_CORE_CLK, // Clock
    input wire logic I_NRST, // Reset, low
    input wire logic I_CE, // Enable
    input wire logic I_SCLK, // Serial clock
    input wire logic I_SDI, // Serial data
    input wire logic I_LATCH_LOAD, // Latch load
    input wire logic I_OUTPUT_BLANK, // Blank
    input wire logic I_SUPPLY_LOW_LOCKOUT, // Lockout
    input wire logic I_OVERHEAT_SHUTOFF, // Overheat
    input wire logic [CHANNELS-1:0] I_DROP_OK, // Drop ok
    input wire logic O_SDO, // Serial out
    input wire logic [CHANNELS-1:0] O_SINK_ON, // Sinks
    input wire logic O_TEST_MODE // Test mode
);
    logic sclk_q; // Last serial clock
    logic blank_q; // Last blank
    logic ev_q; // Chain event one cycle ago
    logic ev_qq; // Chain event two cycles ago
    logic rise; // Serial clock rising now
    logic ev; // Anything allowed to move the chain
    logic quiet; // Latch idle and sinks enabled
    assign rise = I_CE && I_SCLK && !sclk_q;
    assign ev = rise || (I_OUTPUT_BLANK && !blank_q) || I_OVERHEAT_SHUTOFF
        || I_SUPPLY_LOW_LOCKOUT;
    assign quiet = I_CE && !I_LATCH_LOAD && !I_OUTPUT_BLANK
        && !I_SUPPLY_LOW_LOCKOUT && !I_OVERHEAT_SHUTOFF;
    // Input history
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sclk_q <= 1'b0;
            blank_q <= 1'b0;
            ev_q <= 1'b0;
            ev_qq <= 1'b0;
        end else begin
            sclk_q <= I_SCLK;
            blank_q <= I_OUTPUT_BLANK;
            ev_q <= ev;
            ev_qq <= ev_q;
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    blank_off_a: assert property (I_CE && I_OUTPUT_BLANK |=>
        O_SINK_ON == {CHANNELS{1'b0}}) else $error("sinks on while blank");
    heat_off_a: assert property (I_CE && I_OVERHEAT_SHUTOFF |=>
        O_SINK_ON == {CHANNELS{1'b0}}) else $error("sinks on when hot");
    lockout_clear_a: assert property (
        I_CE && I_SUPPLY_LOW_LOCKOUT
        ##1 I_CE && I_SUPPLY_LOW_LOCKOUT |=> !O_SDO && !O_TEST_MODE
        && O_SINK_ON == {CHANNELS{1'b0}}) else $error("lockout not clear");
    latch_hold_a: assert property (quiet[*3] |=>
        $stable(O_SINK_ON)) else $error("sinks moved without load");
    mode_cause_a: assert property ($changed(O_TEST_MODE) |->
        $past(rise, 2) || $past(I_SUPPLY_LOW_LOCKOUT, 2))
        else $error("mode moved without clock");
    entry_last_a: assert property (
        $rose(O_TEST_MODE) |-> $past(rise
        && I_OUTPUT_BLANK == led_sink_pkg::ENTRY_BLANK_LVL[4]
        && I_LATCH_LOAD == led_sink_pkg::ENTRY_LOAD_LVL[4], 2))
        else $error("entry without last step");
    exit_last_a: assert property ($fell(O_TEST_MODE) |->
        $past(I_SUPPLY_LOW_LOCKOUT, 2) || $past(rise
        && I_OUTPUT_BLANK == led_sink_pkg::EXIT_BLANK_LVL[4]
        && I_LATCH_LOAD == led_sink_pkg::EXIT_LOAD_LVL[4], 2))
        else $error("exit without last step");
    sdo_cause_a: assert property ($changed(O_SDO) |->
        ev_q || ev_qq) else $error("serial out moved alone");
    enter_c: cover property ($rose(O_TEST_MODE));
    leave_c: cover property ($fell(O_TEST_MODE));
    load_c: cover property (O_TEST_MODE && I_OUTPUT_BLANK && !blank_q);
endmodule

//--- testbench/led_host_model.sv
// Host model sending serial words to the driver
`timescale 1ns/1ns
module led_host_model #(
    parameter int CHANNELS = 8
) (
    input wire logic i_clk, // Core clock
    input wire logic i_nrst, // Reset, low
    input wire logic i_go, // Start a word
    input wire logic [CHANNELS-1:0] i_word, // Highest bit sent first
    input wire logic [4:0] i_count, // Bits to send
    output logic o_busy, // Word in progress
    output logic o_sclk, // Serial clock
    output logic o_sdi // Serial data
);
    logic [CHANNELS-1:0] word_q; // Word in flight
    logic [4:0] cnt_q; // Bits left
    logic [1:0] ph_q; // Data, high, low phase
    assign o_busy = (cnt_q != 5'h00);
    // Three cycles a bit, clock idle low between words
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            word_q <= '0;
            cnt_q <= 5'h00;
            ph_q <= 2'h0;
            o_sclk <= 1'b0;
            o_sdi <= 1'b0;
        end else if (cnt_q == 5'h00) begin
            o_sclk <= 1'b0;
            o_sdi <= ~o_sdi; // Idle line shows no stale bit
            ph_q <= 2'h0;
            if (i_go) begin
                word_q <= i_word;
                cnt_q <= i_count;
            end
        end else if (ph_q == 2'h0) begin
            o_sdi <= word_q[cnt_q - 5'h01]; // Data ahead of edge
            ph_q <= 2'h1;
        end else if (ph_q == 2'h1) begin
            o_sclk <= 1'b1;
            ph_q <= 2'h2;
        end else begin
            o_sclk <= 1'b0;
            cnt_q <= cnt_q - 5'h01;
            ph_q <= 2'h0;
        end
    end
endmodule

//--- testbench/led_sink_driver_tb_top.sv
// Self-checking bench for the LED sink driver
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    miscompares++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
    end end
module led_sink_driver_tb_top;
    logic core_clk = 1'b0; // 100 MHz clock
    logic nrst = 1'b0; // Reset, low
    logic ce = 1'b1; // Clock enable
    logic blank = 1'b0; // Blank pin
    logic load = 1'b0; // Latch load pin
    logic lockout = 1'b0; // Supply low
    logic overheat = 1'b0; // Overheat
    logic [7:0] drop_ok = 8'h00; // Per channel drop good
    logic go = 1'b0; // Host start
    logic [7:0] word = 8'h00; // Host word
    logic [4:0] nbits = 5'h00; // Host bit count
    logic sclk, sdi, busy, sdo, test_mode; // Serial and mode lines
    logic [7:0] sinks; // Sink outputs
    int miscompares = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    int cycles = 0; // Timeout count
    always #5 core_clk = ~core_clk;
    led_host_model #(.CHANNELS(8)) host (.i_clk(core_clk), .i_nrst(nrst),
        .i_go(go), .i_word(word), .i_count(nbits), .o_busy(busy),
        .o_sclk(sclk), .o_sdi(sdi));
    led_sink_driver #(.CHANNELS(8)) dut (.I_CORE_CLK(core_clk),
        .I_NRST(nrst), .I_CE(ce), .I_SCLK(sclk), .I_SDI(sdi),
        .I_LATCH_LOAD(load), .I_OUTPUT_BLANK(blank),
        .I_SUPPLY_LOW_LOCKOUT(lockout), .I_OVERHEAT_SHUTOFF(overheat),
        .I_DROP_OK(drop_ok), .O_SDO(sdo), .O_SINK_ON(sinks),
        .O_TEST_MODE(test_mode));
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pins(input logic b, input logic l);
        @(posedge core_clk);
        blank <= b;
        load <= l;
    endtask
    task automatic send(input logic [7:0] w, input logic [4:0] n);
        int t;
        t = 0;
        @(posedge core_clk);
        go <= 1'b1;
        word <= w;
        nbits <= n;
        tick(2);
        go <= 1'b0;
        while (busy === 1'b1 && t < 100) begin
            tick(1);
            t++;
        end
        if (t >= 100) miscompares++;
        tick(2);
    endtask
    task automatic latch_now();
        @(posedge core_clk);
        load <= 1'b1;
        tick(2);
        load <= 1'b0;
        tick(2);
    endtask
    task automatic readout(input logic [7:0] e, input logic b);
        pins(b, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            `CHK(sdo, e[i])
            send(8'h00, 5'h01);
        end
    endtask
    task automatic t_normal();
        `CHK({sdo, test_mode, sinks}, 10'h000)
        pins(1'b0, 1'b0);
        send(8'ha5, 5'h08);
        latch_now();
        `CHK(sinks, 8'ha5)
        pins(1'b1, 1'b0);
        tick(2);
        `CHK(sinks, 8'h00)
        pins(1'b0, 1'b0);
        tick(2);
        `CHK(sinks, 8'ha5)
        overheat <= 1'b1;
        tick(2);
        `CHK(sinks, 8'h00)
        overheat <= 1'b0;
        tick(2);
        `CHK(sinks, 8'ha5)
        readout(8'ha5, 1'b0);
    endtask
    task automatic t_test();
        send(8'hff, 5'h08);
        latch_now(); // Pattern latched first
        for (int i = 0; i < 5; i++) begin
            pins(led_sink_pkg::ENTRY_BLANK_LVL[i],
                led_sink_pkg::ENTRY_LOAD_LVL[i]);
            send(8'h00, 5'h01);
        end
        `CHK(test_mode, 1'b1)
        pins(1'b0, 1'b0);
        tick(2);
        `CHK(sinks, 8'hff)
        drop_ok <= 8'hbc;
        send(8'h00, 5'h03); // Three pulses
        tick(200); // Low for two microseconds
        pins(1'b1, 1'b0);
        tick(2);
        readout(8'hbc, 1'b1);
        pins(1'b0, 1'b0);
        send(8'h8f, 5'h08);
        latch_now();
        send(8'h00, 5'h03);
        tick(200);
        pins(1'b1, 1'b0);
        tick(2);
        `CHK(sdo, 1'b1)
        overheat <= 1'b1;
        tick(2);
        overheat <= 1'b0;
        tick(2);
        `CHK(sdo, 1'b0)
        for (int i = 0; i < 5; i++) begin
            pins(led_sink_pkg::EXIT_BLANK_LVL[i],
                led_sink_pkg::EXIT_LOAD_LVL[i]);
            send(8'h00, 5'h01);
        end
        `CHK(test_mode, 1'b0)
    endtask
    task automatic t_lockout();
        pins(1'b0, 1'b0);
        tick(2);
        `CHK(sinks, 8'h8f)
        // Enable low must freeze the lockout response
        ce <= 1'b0;
        lockout <= 1'b1;
        tick(3);
        `CHK(sinks, 8'h8f) // Frozen while enable low
        ce <= 1'b1;
        tick(3);
        `CHK(sinks, 8'h00)
        lockout <= 1'b0;
        tick(2);
        `CHK({sinks, test_mode}, 9'h000)
        // Latches bypassed, blank held high while shifting
        pins(1'b1, 1'b1);
        send(8'h3c, 5'h08);
        `CHK(sinks, 8'h00)
        pins(1'b0, 1'b1);
        tick(2);
        `CHK(sinks, 8'h3c)
        pins(1'b0, 1'b0);
    endtask
    // Main sequence
    initial begin
        tick(16);
        nrst <= 1'b1;
        tick(2);
        t_normal();
        t_test();
        t_lockout();
        stop_test();
    end
endmodule
bind led_sink_driver led_sink_driver_sva #(.CHANNELS(CHANNELS)) u_sva (
    .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_SCLK(I_SCLK),
    .I_SDI(I_SDI), .I_LATCH_LOAD(I_LATCH_LOAD),
    .I_OUTPUT_BLANK(I_OUTPUT_BLANK),
    .I_SUPPLY_LOW_LOCKOUT(I_SUPPLY_LOW_LOCKOUT),
    .I_OVERHEAT_SHUTOFF(I_OVERHEAT_SHUTOFF), .I_DROP_OK(I_DROP_OK),
    .O_SDO(O_SDO), .O_SINK_ON(O_SINK_ON), .O_TEST_MODE(O_TEST_MODE));
